/* hw/alarm_test_pkg.sv */
package alarm_test_pkg;
   // ==========================================================
   // Sizes and codes
   localparam int NUM_OUT = 34;
   localparam int OUT_W = 6;
   localparam logic [OUT_W-1:0] OUT_NONE = 6'h00;
   localparam logic [OUT_W-1:0] OUT_GLOBAL = 6'h23;
   localparam int PV_W = 16;
   localparam int KEY_W = 5;
   localparam int CLK_HZ = 125000000;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);
   localparam logic [7:0] DELAY_RESET = 8'h00;
   typedef enum logic [1:0] {KIND_OFF, KIND_ALARM, KIND_CONTROL} kind_type;
   typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_TUNE} mode_type;
   typedef enum logic [2:0] {
      T_IDLE, T_INPUTS, T_SELECT, T_FORCE, T_KEYPAD, T_DISPLAY
   } test_type;
endpackage : alarm_test_pkg

/* hw/loop_alarm_and_io_test.sv */
`timescale 1ns/1ps
module loop_alarm_and_io_test #(
   parameter int SEC_CYCLES = alarm_test_pkg::SEC_CYCLES
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic signed [15:0] process_value,
   input wire logic signed [15:0] set_point,
   input wire logic signed [15:0] upper_process_threshold,
   input wire logic signed [15:0] lower_process_threshold,
   input wire logic [7:0] deviation_band,
   input wire logic [7:0] alarm_deadband,
   input wire logic [7:0] alarm_delay_sec,
   input wire logic [1:0] upper_process_alarm_kind,
   input wire logic [1:0] upper_deviation_alarm_kind,
   input wire logic [1:0] lower_deviation_alarm_kind,
   input wire logic [1:0] lower_process_alarm_kind,
   input wire logic [5:0] upper_process_out_sel,
   input wire logic [5:0] upper_deviation_out_sel,
   input wire logic [5:0] lower_deviation_out_sel,
   input wire logic [5:0] lower_process_out_sel,
   input wire logic [33:0] control_claimed,
   input wire logic sensor_failed,
   input wire logic [1:0] loop_mode,
   input wire logic [7:0] digital_in_n,
   input wire logic test_active,
   input wire logic [5:0] test_select,
   input wire logic test_select_strobe,
   input wire logic force_on_strobe,
   input wire logic force_off_strobe,
   input wire logic key_strobe,
   input wire logic [4:0] key_code,
   input wire logic key_is_no,
   input wire logic key_is_yes,
   input wire logic display_test_start,
   output logic [3:0] alarm_active,
   output logic [3:0] alarm_controls,
   output logic sensor_fail_alarm,
   output logic force_manual,
   output logic [33:0] output_sink,
   output logic global_alarm_output,
   output logic [7:0] input_view,
   output logic force_step_offered,
   output logic keypad_test_running,
   output logic [4:0] last_key,
   output logic display_pattern_on,
   output logic display_pattern_phase
);
   // ==========================================================
   // Alarm evaluation

   logic [26:0] sec_cnt_reg, sec_cnt_next;
   logic sec_tick;
   logic [3:0] raw_cond;
   logic [3:0] latch_reg, latch_next;
   logic [7:0] hold_reg [0:4];
   logic [7:0] hold_next [0:4];
   logic sf_reg, sf_next;
   logic [1:0] kind [0:3];
   logic [5:0] sel [0:3];
   logic [33:0] route_mask;

   // Returns true when an output number 1..34 is free of control duty.
   function automatic logic free_out(input logic [5:0] n,
                                     input logic [33:0] claimed);
      free_out = (n >= 6'h01) && (n <= 6'(alarm_test_pkg::NUM_OUT)) &&
         !claimed[n - 6'h01];
   endfunction : free_out

   assign kind[0] = upper_process_alarm_kind;
   assign kind[1] = upper_deviation_alarm_kind;
   assign kind[2] = lower_deviation_alarm_kind;
   assign kind[3] = lower_process_alarm_kind;
   assign sel[0] = upper_process_out_sel;
   assign sel[1] = upper_deviation_out_sel;
   assign sel[2] = lower_deviation_out_sel;
   assign sel[3] = lower_process_out_sel;

   // Threshold conditions with hysteresis; index 0..3 = HP, HD, LD, LP.
   always_comb begin
      logic signed [17:0] pv, hp, hd, ld, lp, db;
      pv = 18'(process_value);
      db = 18'({10'h000, alarm_deadband});
      hp = 18'(upper_process_threshold);
      lp = 18'(lower_process_threshold);
      hd = 18'(set_point) + 18'({10'h000, deviation_band});
      ld = 18'(set_point) - 18'({10'h000, deviation_band});
      raw_cond[0] = latch_reg[0] ? (pv >= hp - db) : (pv >= hp);
      raw_cond[1] = latch_reg[1] ? (pv >= hd - db) : (pv >= hd);
      raw_cond[2] = latch_reg[2] ? (pv <= ld + db) : (pv <= ld);
      raw_cond[3] = latch_reg[3] ? (pv <= lp + db) : (pv <= lp);
   end

   // Second tick, per-alarm persistence counters and latches.
   always_comb begin
      logic [4:0] cond;
      cond = {sensor_failed, raw_cond};
      sec_tick = (sec_cnt_reg == 27'(SEC_CYCLES - 1));
      sec_cnt_next = sec_tick ? 27'h0000000 : sec_cnt_reg + 27'h0000001;
      // A disabled alarm never sees its condition.
      for (int i = 0; i < 4; i++) begin
         if (kind[i] == alarm_test_pkg::KIND_OFF) begin
            cond[i] = 1'b0;
         end
      end
      // Count whole seconds of an unbroken condition, saturating at the top.
      for (int i = 0; i < 5; i++) begin
         hold_next[i] = hold_reg[i];
         if (!cond[i]) begin
            hold_next[i] = 8'h00;
         end else if (sec_tick && hold_reg[i] != 8'hFF) begin
            hold_next[i] = hold_reg[i] + 8'h01;
         end
      end
      // Reported once held strictly longer than the delay.
      for (int i = 0; i < 4; i++) begin
         latch_next[i] = cond[i] && (latch_reg[i] ||
            (hold_reg[i] > alarm_delay_sec));
      end
      sf_next = cond[4] && (sf_reg ||
         (hold_reg[4] > alarm_delay_sec));
   end

   // Registers of the alarm group.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sec_cnt_reg <= 27'h0000000;
         latch_reg <= 4'h0;
         sf_reg <= 1'b0;
         for (int i = 0; i < 5; i++) begin
            hold_reg[i] <= alarm_test_pkg::DELAY_RESET;
         end
      end else begin
         sec_cnt_reg <= sec_cnt_next;
         latch_reg <= latch_next;
         sf_reg <= sf_next;
         for (int i = 0; i < 5; i++) begin
            hold_reg[i] <= hold_next[i];
         end
      end
   end

   // Alarm outputs, routing and manual fallback.
   always_comb begin
      route_mask = 34'h000000000;
      for (int i = 0; i < 4; i++) begin
         alarm_active[i] = latch_reg[i];
         alarm_controls[i] = latch_reg[i] &&
            (kind[i] == alarm_test_pkg::KIND_CONTROL);
         if (latch_reg[i] && free_out(sel[i], control_claimed)) begin
            route_mask[sel[i] - 6'h01] = 1'b1;
         end
      end
      sensor_fail_alarm = sf_reg;
      force_manual = sf_reg &&
         (loop_mode == alarm_test_pkg::MODE_AUTO ||
          loop_mode == alarm_test_pkg::MODE_TUNE);
   end

   // ==========================================================
   // Manual I/O test

   logic [5:0] chosen_reg, chosen_next;
   logic [33:0] forced_reg, forced_next;
   logic ga_forced_reg, ga_forced_next;
   logic [7:0] in_reg, in_next;
   logic kp_run_reg, kp_run_next;
   logic [1:0] no_cnt_reg, no_cnt_next;
   logic [4:0] key_reg, key_next;
   logic disp_run_reg, disp_run_next;
   logic disp_on_reg, disp_on_next;
   logic disp_ph_reg, disp_ph_next;
   logic chosen_ok;

   // Next values of the selection, forcing, keypad and display tests.
   always_comb begin
      chosen_ok = free_out(chosen_reg, control_claimed) ||
         (chosen_reg == alarm_test_pkg::OUT_GLOBAL);
      in_next = ~digital_in_n;
      chosen_next = chosen_reg;
      forced_next = forced_reg & ~control_claimed;
      ga_forced_next = ga_forced_reg;
      kp_run_next = kp_run_reg;
      no_cnt_next = no_cnt_reg;
      key_next = key_reg;
      disp_run_next = disp_run_reg;
      disp_on_next = disp_on_reg;
      disp_ph_next = disp_ph_reg;
      if (!test_active) begin
         forced_next = 34'h000000000;
         ga_forced_next = 1'b0;
         kp_run_next = 1'b0;
         no_cnt_next = 2'h0;
         disp_run_next = 1'b0;
         disp_on_next = 1'b0;
         disp_ph_next = 1'b0;
      end else begin
         if (test_select_strobe) begin
            chosen_next = test_select;
         end
         if (chosen_ok && (force_on_strobe || force_off_strobe)) begin
            if (chosen_reg == alarm_test_pkg::OUT_GLOBAL) begin
               ga_forced_next = force_on_strobe;
            end else begin
               forced_next[chosen_reg - 6'h01] = force_on_strobe;
            end
         end
         if (!kp_run_reg && !disp_run_reg && display_test_start) begin
            disp_run_next = 1'b1;
         end else if (disp_run_reg && key_strobe && key_is_yes) begin
            disp_ph_next = disp_on_reg ? ~disp_ph_reg : 1'b0;
            disp_on_next = 1'b1;
         end else if (disp_run_reg && key_strobe && key_is_no) begin
            disp_run_next = 1'b0;
            disp_on_next = 1'b0;
            disp_ph_next = 1'b0;
         end else if (!kp_run_reg && !disp_run_reg && key_strobe) begin
            kp_run_next = 1'b1;
            key_next = key_code;
            no_cnt_next = key_is_no ? 2'h1 : 2'h0;
         end else if (kp_run_reg && key_strobe) begin
            key_next = key_code;
            if (key_is_no) begin
               no_cnt_next = no_cnt_reg + 2'h1;
               if (no_cnt_reg == 2'h1) begin
                  kp_run_next = 1'b0;
                  no_cnt_next = 2'h0;
               end
            end
         end
      end
   end

   // Registers of the test group.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         chosen_reg <= alarm_test_pkg::OUT_NONE;
         forced_reg <= 34'h000000000;
         ga_forced_reg <= 1'b0;
         in_reg <= 8'h00;
         kp_run_reg <= 1'b0;
         no_cnt_reg <= 2'h0;
         key_reg <= 5'h00;
         disp_run_reg <= 1'b0;
         disp_on_reg <= 1'b0;
         disp_ph_reg <= 1'b0;
      end else begin
         chosen_reg <= chosen_next;
         forced_reg <= forced_next;
         ga_forced_reg <= ga_forced_next;
         in_reg <= in_next;
         kp_run_reg <= kp_run_next;
         no_cnt_reg <= no_cnt_next;
         key_reg <= key_next;
         disp_run_reg <= disp_run_next;
         disp_on_reg <= disp_on_next;
         disp_ph_reg <= disp_ph_next;
      end
   end

   // Test outputs; a sink line is on when routed or forced.
   // A claim for control takes the line away at once, not a cycle later.
   assign output_sink = (route_mask | forced_reg) & ~control_claimed;
   assign global_alarm_output = (|latch_reg) | sf_reg | ga_forced_reg;
   assign input_view = in_reg;
   assign force_step_offered = test_active && chosen_ok;
   assign keypad_test_running = kp_run_reg;
   assign last_key = key_reg;
   assign display_pattern_on = disp_on_reg;
   assign display_pattern_phase = disp_ph_reg;
endmodule : loop_alarm_and_io_test

/* test/process_field.sv */
`timescale 1ns/1ps
// ========
// Field model: contacts, sensor level and output loads.
module process_field (
   input wire logic [7:0] contact_closed,
   input wire logic signed [15:0] level,
   input wire logic [33:0] output_sink,
   output logic [7:0] digital_in_n,
   output logic signed [15:0] process_value,
   output logic [33:0] load_current
);
   // Open contacts float high on their pull-ups.
   assign digital_in_n = ~contact_closed;
   assign process_value = level;
   // A load draws current only while its output sinks.
   assign load_current = output_sink;
endmodule : process_field

/* test/alarm_rules_checker.sv */
`timescale 1ns/1ps
// ========
// Port-level checks of the alarm and test logic.
module alarm_rules_checker #(
   parameter int SEC_CYCLES = 10
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [7:0] digital_in_n,
   input wire logic [7:0] input_view,
   input wire logic sensor_failed,
   input wire logic sensor_fail_alarm,
   input wire logic force_manual,
   input wire logic [1:0] loop_mode,
   input wire logic [33:0] output_sink,
   input wire logic [33:0] control_claimed,
   input wire logic force_step_offered,
   input wire logic test_active,
   input wire logic keypad_test_running,
   input wire logic display_pattern_on,
   input wire logic display_pattern_phase,
   input wire logic key_strobe,
   input wire logic key_is_yes,
   input wire logic [3:0] alarm_active,
   input wire logic [3:0] alarm_controls,
   input wire logic [1:0] upper_process_alarm_kind
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sink_unclaimed_a: assert property (
      (output_sink & control_claimed) == 34'h000000000)
      else $error("claimed output is sinking");
   input_view_a: assert property (
      $past(nrst) |-> input_view == ~$past(digital_in_n))
      else $error("input view wrong");
   manual_switch_a: assert property (
      force_manual == (sensor_fail_alarm && loop_mode inside {2'h1, 2'h2}))
      else $error("manual switch wrong");
   fail_hold_a: assert property (
      $rose(sensor_fail_alarm) |->
      $past(sensor_failed) && $past(sensor_failed, 2))
      else $error("early fail");
   kind_off_a: assert property (
      upper_process_alarm_kind == 2'h0 &&
      $past(upper_process_alarm_kind) == 2'h0 |-> !alarm_active[0])
      else $error("disabled alarm active");
   control_only_a: assert property (
      (alarm_controls & ~alarm_active) == 4'h0)
      else $error("control without alarm");
   exit_clear_a: assert property (
      !test_active && !$past(test_active) |->
      !force_step_offered && !keypad_test_running && !display_pattern_on)
      else $error("test state kept after exit");
   phase_toggle_a: assert property (
      key_strobe && key_is_yes && test_active && display_pattern_on |=>
      display_pattern_phase != $past(display_pattern_phase))
      else $error("pattern did not toggle");
endmodule : alarm_rules_checker
bind loop_alarm_and_io_test alarm_rules_checker #(
   .SEC_CYCLES(SEC_CYCLES)
) i_chk (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .digital_in_n(digital_in_n),
   .input_view(input_view),
   .sensor_failed(sensor_failed),
   .sensor_fail_alarm(sensor_fail_alarm),
   .force_manual(force_manual),
   .loop_mode(loop_mode),
   .output_sink(output_sink),
   .control_claimed(control_claimed),
   .force_step_offered(force_step_offered),
   .test_active(test_active),
   .keypad_test_running(keypad_test_running),
   .display_pattern_on(display_pattern_on),
   .display_pattern_phase(display_pattern_phase),
   .key_strobe(key_strobe),
   .key_is_yes(key_is_yes),
   .alarm_active(alarm_active),
   .alarm_controls(alarm_controls),
   .upper_process_alarm_kind(upper_process_alarm_kind)
);

/* test/loop_alarm_and_io_test_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
   fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
// ========
// Bench for the loop alarms and the manual test facility.
module loop_alarm_and_io_test_tb;
   logic clk_sys, nrst, sensor_failed, test_active, key_is_no, key_is_yes;
   logic signed [15:0] level, process_value, set_point, upper_process_threshold;
   logic signed [15:0] lower_process_threshold;
   logic [7:0] deviation_band, alarm_deadband, alarm_delay_sec;
   logic [7:0] contact_closed, digital_in_n, input_view;
   logic [1:0] upper_process_alarm_kind, upper_deviation_alarm_kind, loop_mode;
   logic [1:0] lower_deviation_alarm_kind, lower_process_alarm_kind;
   logic [5:0] upper_process_out_sel, upper_deviation_out_sel, test_select;
   logic [5:0] lower_deviation_out_sel, lower_process_out_sel;
   logic [33:0] control_claimed, output_sink, load_current;
   logic [4:0] key_code, stb, last_key;
   logic test_select_strobe, force_on_strobe, force_off_strobe, key_strobe;
   logic display_test_start, sensor_fail_alarm, force_manual, global_alarm_output;
   logic force_step_offered, keypad_test_running;
   logic display_pattern_on, display_pattern_phase;
   logic [3:0] alarm_active, alarm_controls;
   logic signed [15:0] lv [5] = '{16'sh64, 16'sh63, 16'sh61, -16'sh64, 16'sh2D};
   logic [3:0] ex [5] = '{4'h3, 4'h3, 4'h2, 4'hC, 4'h0};
   int fail_count = 0, samples_checked = 0, i;
   assign {display_test_start, key_strobe, force_off_strobe, force_on_strobe,
      test_select_strobe} = stb;
   loop_alarm_and_io_test #(.SEC_CYCLES(10)) i_dut (.*);
   process_field i_field (.*);
   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : settle
   // One-cycle strobe b with its selection and key fields.
   task automatic pulse(input int b, input logic [5:0] s, input logic [1:0] ny);
      @(posedge clk_sys);
      stb[b] <= 1'b1;
      test_select <= s;
      key_code <= s[4:0];
      {key_is_no, key_is_yes} <= ny;
      @(posedge clk_sys);
      stb <= 5'h00;
      @(negedge clk_sys);
   endtask : pulse
   // Hang guard.
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      {nrst, sensor_failed, test_active, key_is_no, key_is_yes, stb} = '0;
      {test_select, key_code, loop_mode, contact_closed, alarm_delay_sec} = '0;
      // Output 3 is claimed, so the deviation route must stay dark.
      {upper_process_out_sel, upper_deviation_out_sel} = {6'h05, 6'h03};
      {lower_deviation_out_sel, lower_process_out_sel} = '0;
      {upper_process_alarm_kind, upper_deviation_alarm_kind} = 4'h5;
      {lower_deviation_alarm_kind, lower_process_alarm_kind} = 4'h5;
      control_claimed = 34'h4;
      set_point = 16'sh32;
      deviation_band = 8'h0A;
      alarm_deadband = 8'h02;
      upper_process_threshold = 16'sh64;
      lower_process_threshold = -16'sh32;
      level = 16'sh2D;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys) contact_closed <= 8'h81;
      settle(2);
      `CHK("input_view", 8'h81, input_view)
      $display("test inputs done");
      for (i = 0; i < 5; i++) begin
         @(posedge clk_sys) level <= lv[i];
         settle(25);
         `CHK("alarm_active", ex[i], alarm_active)
         `CHK("load_current", {29'h0, ex[i][0], 4'h0}, load_current)
      end
      @(posedge clk_sys) {level, upper_process_alarm_kind} <= {16'sh64, 2'h2};
      settle(25);
      `CHK("alarm_controls", 4'h1, alarm_controls)
      @(posedge clk_sys) upper_process_alarm_kind <= 2'h0;
      settle(2);
      `CHK("alarm_active", 4'h2, alarm_active)
      $display("test alarms done");
      // Two seconds of delay need three ticks, at least 21 cycles.
      @(posedge clk_sys) begin
         alarm_delay_sec <= 8'h02;
         {sensor_failed, loop_mode} <= 3'h5;
      end
      settle(20);
      `CHK("sensor_fail_alarm", 1'b0, sensor_fail_alarm)
      for (i = 0; i < 40 && sensor_fail_alarm !== 1'b1; i++) settle(0);
      // A wait that runs out counts as a mismatch.
      if (i == 40) fail_count++;
      `CHK("force_manual", 1'b1, force_manual)
      @(posedge clk_sys) loop_mode <= 2'h2;
      settle(0);
      `CHK("force_manual", 1'b1, force_manual)
      @(posedge clk_sys) loop_mode <= 2'h0;
      settle(0);
      `CHK("force_manual", 1'b0, force_manual)
      @(posedge clk_sys) begin
         {sensor_failed, test_active} <= 2'h1;
         level <= 16'sh2D;
      end
      settle(25);
      $display("test sensor done");
      pulse(0, 6'h03, 2'h0);
      `CHK("force_step_offered", 1'b0, force_step_offered)
      pulse(1, 6'h03, 2'h0);
      `CHK("load_current", 34'h0, load_current)
      pulse(0, 6'h07, 2'h0);
      `CHK("force_step_offered", 1'b1, force_step_offered)
      pulse(1, 6'h07, 2'h0);
      `CHK("load_current", 34'h40, load_current)
      pulse(2, 6'h07, 2'h0);
      `CHK("load_current", 34'h0, load_current)
      pulse(0, 6'h23, 2'h0);
      pulse(1, 6'h23, 2'h0);
      `CHK("global_alarm_output", 1'b1, global_alarm_output)
      pulse(0, 6'h07, 2'h0);
      pulse(1, 6'h07, 2'h0);
      @(posedge clk_sys) test_active <= 1'b0;
      settle(2);
      `CHK("outputs", 35'h0, {global_alarm_output, load_current})
      $display("test outputs done");
      @(posedge clk_sys) test_active <= 1'b1;
      pulse(3, 6'h09, 2'h0);
      `CHK("keypad", 6'h29, {keypad_test_running, last_key})
      pulse(3, 6'h01, 2'h2);
      `CHK("keypad_test_running", 1'b1, keypad_test_running)
      pulse(3, 6'h01, 2'h2);
      `CHK("keypad_test_running", 1'b0, keypad_test_running)
      pulse(4, 6'h00, 2'h0);
      pulse(3, 6'h02, 2'h1);
      `CHK("display", 2'h2, {display_pattern_on, display_pattern_phase})
      pulse(3, 6'h02, 2'h1);
      `CHK("display", 2'h3, {display_pattern_on, display_pattern_phase})
      pulse(3, 6'h01, 2'h2);
      `CHK("display_pattern_on", 1'b0, display_pattern_on)
      @(posedge clk_sys) test_active <= 1'b0;
      settle(2);
      $display("test keypad and display done");
      tally_and_finish();
   end
endmodule : loop_alarm_and_io_test_tb
